//--- rtl/mem_ctrl_regs.svh
// Constants for the external memory controller pin block.
`ifndef MEM_CTRL_REGS_SVH
`define MEM_CTRL_REGS_SVH
`define BANK_COUNT      8
`define LANE_COUNT      8
`define PROG_LINES      6
`define BANK_SEL_W      3
`define ADDR_W          32
`define ADDR_TEN_BIT    10
`define BURST_BEATS     4
`define BURST_BITS_W    2
`define MACH_W          2
`define BCTL_CFG_W      2
`define PAT_LEN         4
`define PAT_IDX_W       2
`define SDRAM_TRCD      2
`define SDRAM_TCNT_W    3
`define CHIPSEL_TIMEOUT 8'hff
`endif

//--- rtl/mem_ctrl_pkg.sv
// Types shared by the memory controller modules.
package mem_ctrl_pkg;
    typedef enum logic [1:0] {
        MACH_CHIPSEL,
        MACH_USERPROG,
        MACH_SDRAM,
        MACH_NONE
    } machine_sel_t;

    typedef enum logic [1:0] {
        BUF_DIR_EN,
        BUF_READ_WRITE,
        BUF_SPLIT,
        BUF_OFF
    } buffer_mode_t;
endpackage

//--- rtl/lane_if.sv
// Interface carrying access shape from the main controller to the lane decoder.
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
    logic [2:0] addr_lo;
    logic [3:0] size_bytes;
    logic [3:0] port_bytes;
    logic [7:0] lanes;
    modport ctrl (output addr_lo, output size_bytes, output port_bytes, input lanes);
    modport dec  (input addr_lo, input size_bytes, input port_bytes, output lanes);
endinterface
`default_nettype wire

//--- rtl/lane_decode.sv
// Byte lane decoder from address, transfer size and port size.
`timescale 1ns/1ps
`default_nettype none
`include "mem_ctrl_regs.svh"
module lane_decode
    import mem_ctrl_pkg::*;
(
    lane_if.dec lif
);
    // Narrow ports fold the address onto their own lane group.
    wire [3:0] port_w = (lif.port_bytes == 4'h0) ? 4'h8 : lif.port_bytes;
    wire [2:0] start  = lif.addr_lo & ~(port_w[2:0] - 3'h1) & ~{port_w[3], 2'h0} |
                        (lif.addr_lo & (port_w[2:0] - 3'h1));
    wire [3:0] base   = {1'b0, start} % port_w;
    genvar g;
    generate
        for (g = 0; g < `LANE_COUNT; g = g + 1) begin : g_lane
            assign lif.lanes[g] = (4'(g) >= base) && (4'(g) < base + lif.size_bytes)
                                  && (4'(g) < port_w);
        end
    endgenerate
endmodule
`default_nettype wire

//--- rtl/external_memory_controller.sv
// External memory controller pin block with chip-select, user and SDRAM machines.
// Overview of operation
// - Eight bank selects, one asserted for the bank an access falls in.
// - Chip-select machine write enables assert only the lanes a write touches.
// - Chip-select machine output enable is asserted during reads.
// - The chip-select access ends when the external acknowledge of its last beat is seen.
// - The SDRAM machine drives eight byte masks selecting the active lanes.
// - SDRAM address bit ten carries address with the row, command with the column.
// - The SDRAM machine drives write, row and column strobes.
// - In external master mode the SDRAM machine steers the address multiplexer.
// - In external master configuration an address latch enable is driven.
// - User machine byte selects follow the pattern, address, size and port size.
// - Six general lines take value and timing from the pattern, with each step held while the wait input is high.
// - The user machine stalls while the wait input is high.
// - A parity chip select is driven when parity lives in its own chip.
// - Two buffer controls whose function is set by a configuration field.
// - Burst address bits increment across burst beats.
`timescale 1ns/1ps
`default_nettype none
`include "mem_ctrl_regs.svh"
module external_memory_controller
    import mem_ctrl_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [`ADDR_W-1:0]         req_addr,
    input  wire logic [`BANK_SEL_W-1:0]     req_bank,
    input  wire logic [3:0]                 req_size,
    input  wire logic                       req_burst,
    input  wire logic [15:0]                bank_machine,
    input  wire logic [31:0]                bank_port_size,
    input  wire logic [`PAT_LEN*6-1:0]      prog_pattern,
    input  wire logic [`PAT_LEN-1:0]        prog_bs_pattern,
    input  wire logic [`BCTL_CFG_W-1:0]     buffer_ctrl_config,
    input  wire logic                       ext_master_mode,
    input  wire logic                       parity_sep_en,
    input  wire logic                       chipsel_machine_ack,
    input  wire logic                       prog_machine_wait,
    output logic                            req_ready,
    output logic                            req_done,
    output logic [`BANK_COUNT-1:0]          bank_select_n,
    output logic [`LANE_COUNT-1:0]          lane_write_en_n,
    output logic                            mem_output_en_n,
    output logic [`LANE_COUNT-1:0]          sdram_byte_mask,
    output logic                            sdram_addr_bit_ten,
    output logic                            sdram_write_strobe_n,
    output logic                            sdram_row_strobe_n,
    output logic                            sdram_col_strobe_n,
    output logic                            sdram_addr_mux_ctrl,
    output logic                            addr_latch_en,
    output logic [`LANE_COUNT-1:0]          prog_byte_select_n,
    output logic [`PROG_LINES-1:0]          prog_line,
    output logic                            parity_chip_select_n,
    output logic                            buffer_ctrl_a,
    output logic                            buffer_ctrl_b,
    output logic [`BURST_BITS_W-1:0]        burst_addr_bits
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LATCH,
        ST_CS_WAIT,
        ST_UP_RUN,
        ST_SD_ROW,
        ST_SD_COL,
        ST_DONE
    } state_t;

    state_t                  state_r, state_nxt;
    logic                    write_r;
    logic [`ADDR_W-1:0]      addr_r;
    logic [`BANK_SEL_W-1:0]  bank_r;
    logic [3:0]              size_r;
    logic                    burst_r;
    machine_sel_t            mach_r;
    logic [`BURST_BITS_W-1:0] beat_r;
    logic [`PAT_IDX_W-1:0]   pat_r;
    logic [`SDRAM_TCNT_W-1:0] tcnt_r;
    logic [`LANE_COUNT-1:0]  lanes_r;
    logic [`BURST_BITS_W-1:0] nbeat_r;

    lane_if lif();
    assign lif.addr_lo    = req_addr[2:0];
    assign lif.size_bytes = req_size;
    assign lif.port_bytes = bank_port_size[req_bank*4 +: 4];

    lane_decode u_lane (
        .lif (lif)
    );

    // Bank setup chooses the single machine that owns the access.
    wire machine_sel_t req_mach = machine_sel_t'(bank_machine[req_bank*2 +: 2]);
    wire       take        = (state_r == ST_IDLE) && req_valid;
    wire       last_beat   = !burst_r || (nbeat_r == `BURST_BITS_W'(`BURST_BEATS-1));
    wire       pat_end     = (pat_r == `PAT_IDX_W'(`PAT_LEN-1));
    wire       up_step     = !prog_machine_wait;
    wire       active      = (state_r != ST_IDLE) && (state_r != ST_DONE);
    wire       in_cs       = active && (mach_r == MACH_CHIPSEL);
    wire       in_up       = (state_r == ST_UP_RUN);
    wire       in_sd       = (state_r == ST_SD_ROW) || (state_r == ST_SD_COL);
    // The registered pattern outputs show the step the machine moves to, so no step is lost.
    wire [`PAT_IDX_W-1:0] pat_next = (in_up && up_step) ? pat_r + `PAT_IDX_W'(1) : pat_r;
    wire [5:0] pat_lines   = prog_pattern[pat_next*6 +: 6];

    // Next-state selection; every access passes through the latch phase, whatever the master mode.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (req_valid && req_mach != MACH_NONE) begin
                    state_nxt = ST_LATCH;
                end
            end
            ST_LATCH: begin
                case (mach_r)
                    MACH_CHIPSEL:  state_nxt = ST_CS_WAIT;
                    MACH_USERPROG: state_nxt = ST_UP_RUN;
                    MACH_SDRAM:    state_nxt = ST_SD_ROW;
                    default:       state_nxt = ST_IDLE;
                endcase
            end
            ST_CS_WAIT: begin
                if (chipsel_machine_ack && last_beat) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_UP_RUN: begin
                if (up_step && pat_end && last_beat) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_SD_ROW: begin
                if (tcnt_r == `SDRAM_TCNT_W'(`SDRAM_TRCD)) begin
                    state_nxt = ST_SD_COL;
                end
            end
            ST_SD_COL: begin
                if (last_beat) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE:  state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // Access capture and the state register.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            write_r <= 1'b0;
            addr_r  <= '0;
            bank_r  <= '0;
            size_r  <= '0;
            burst_r <= 1'b0;
            mach_r  <= MACH_NONE;
            lanes_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                write_r <= req_write;
                addr_r  <= req_addr;
                bank_r  <= req_bank;
                size_r  <= req_size;
                burst_r <= req_burst;
                mach_r  <= req_mach;
                lanes_r <= lif.lanes;
            end
        end
    end

    // Beat, pattern and SDRAM delay counters; the beat feeds the burst address.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            beat_r  <= '0;
            nbeat_r <= '0;
            pat_r   <= '0;
            tcnt_r  <= '0;
        end else if (take) begin
            beat_r  <= req_addr[4:3];
            nbeat_r <= '0;
            pat_r   <= '0;
            tcnt_r  <= '0;
        end else begin
            // Beats are counted apart from the address bits, since a burst may start mid-line.
            if ((state_r == ST_CS_WAIT && chipsel_machine_ack) ||
                (state_r == ST_SD_COL) || (in_up && up_step && pat_end)) begin
                beat_r  <= beat_r + `BURST_BITS_W'(1);
                nbeat_r <= nbeat_r + `BURST_BITS_W'(1);
            end
            if (in_up && up_step) begin
                pat_r <= pat_r + `PAT_IDX_W'(1);
            end
            if (state_r == ST_SD_ROW) begin
                tcnt_r <= tcnt_r + `SDRAM_TCNT_W'(1);
            end
        end
    end

    // Pin outputs are registered so they change only on the clock edge.
    // Strobes of machines not owning the access are held inactive.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_ready            <= 1'b0;
            req_done             <= 1'b0;
            bank_select_n        <= '1;
            lane_write_en_n      <= '1;
            mem_output_en_n      <= 1'b1;
            sdram_byte_mask      <= '1;
            sdram_addr_bit_ten   <= 1'b0;
            sdram_write_strobe_n <= 1'b1;
            sdram_row_strobe_n   <= 1'b1;
            sdram_col_strobe_n   <= 1'b1;
            sdram_addr_mux_ctrl  <= 1'b0;
            addr_latch_en        <= 1'b0;
            prog_byte_select_n   <= '1;
            prog_line            <= '0;
            parity_chip_select_n <= 1'b1;
            buffer_ctrl_a        <= 1'b0;
            buffer_ctrl_b        <= 1'b0;
            burst_addr_bits      <= '0;
        end else begin
            req_ready <= (state_nxt == ST_IDLE);
            req_done  <= (state_nxt == ST_DONE);
            bank_select_n <= ~((active && state_nxt != ST_DONE)
                               ? (`BANK_COUNT'(1) << bank_r) : `BANK_COUNT'(0));
            lane_write_en_n <= ~((state_nxt == ST_CS_WAIT && write_r)
                                 ? lanes_r : `LANE_COUNT'(0));
            mem_output_en_n <= ~(state_nxt == ST_CS_WAIT && !write_r);
            sdram_byte_mask <= (state_nxt == ST_SD_COL) ? ~lanes_r : '1;
            // Row phase carries the address bit, column phase the precharge flag.
            sdram_addr_bit_ten <= (state_nxt == ST_SD_ROW) ? addr_r[`ADDR_TEN_BIT] :
                                  (state_nxt == ST_SD_COL) ? !burst_r : 1'b0;
            sdram_row_strobe_n   <= ~(state_r == ST_LATCH && state_nxt == ST_SD_ROW);
            sdram_col_strobe_n   <= ~(state_nxt == ST_SD_COL);
            sdram_write_strobe_n <= ~(state_nxt == ST_SD_COL && write_r);
            sdram_addr_mux_ctrl  <= ext_master_mode && (state_nxt == ST_SD_COL);
            addr_latch_en        <= ext_master_mode && (state_nxt == ST_LATCH);
            prog_byte_select_n   <= ~((state_nxt == ST_UP_RUN && prog_bs_pattern[pat_next])
                                      ? lanes_r : `LANE_COUNT'(0));
            prog_line            <= (state_nxt == ST_UP_RUN) ? pat_lines : '0;
            parity_chip_select_n <= ~(parity_sep_en && active && state_nxt != ST_DONE);
            burst_addr_bits      <= beat_r;
            // Buffer controls decode the configuration field.
            case (buffer_mode_t'(buffer_ctrl_config))
                BUF_DIR_EN: begin
                    buffer_ctrl_a <= !write_r;
                    buffer_ctrl_b <= !(in_cs || in_up || in_sd);
                end
                BUF_READ_WRITE: begin
                    buffer_ctrl_a <= (in_cs || in_up || in_sd) && write_r;
                    buffer_ctrl_b <= (in_cs || in_up || in_sd) && !write_r;
                end
                BUF_SPLIT: begin
                    buffer_ctrl_a <= (in_cs || in_up || in_sd);
                    buffer_ctrl_b <= (in_cs || in_up || in_sd);
                end
                default: begin
                    buffer_ctrl_a <= 1'b0;
                    buffer_ctrl_b <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- sim/mem_device_model.sv
// Behavioural memory device that answers the chip-select and user machines.
`timescale 1ns/1ps
`default_nettype none
module mem_device_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] bank_select_n,
    input  wire logic [7:0] lane_write_en_n,
    input  wire logic       mem_output_en_n,
    input  wire logic [7:0] prog_byte_select_n,
    input  wire logic [3:0] ack_dly,
    input  wire logic [3:0] wait_len,
    output logic            chipsel_machine_ack,
    output logic            prog_machine_wait
);
    logic [3:0] cnt_r;
    logic [3:0] wcnt_r;
    logic       armed_r;
    wire        cs_act = (lane_write_en_n != 8'hff) || !mem_output_en_n;
    wire        pb_act = prog_byte_select_n != 8'hff;

    // A slow device acknowledges a beat only after ack_dly cycles of strobe.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            chipsel_machine_ack <= 1'b0;
        end else begin
            chipsel_machine_ack <= cs_act && !chipsel_machine_ack && cnt_r == ack_dly;
            cnt_r <= (cs_act && cnt_r != ack_dly) ? cnt_r + 4'h1 : 4'h0;
        end
    end

    // The wait is raised once per access, so a stall cannot repeat forever.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wcnt_r <= 4'h0;
            armed_r <= 1'b0;
        end else begin
            armed_r <= (bank_select_n != 8'hff) && (armed_r || pb_act);
            wcnt_r <= (pb_act && !armed_r) ? wait_len : (wcnt_r != 4'h0 ? wcnt_r - 4'h1 : 4'h0);
        end
    end

    assign prog_machine_wait = wcnt_r != 4'h0;
endmodule
`default_nettype wire

//--- sim/external_memory_controller_sva.sv
// Concurrent checks on the memory controller pins.
`timescale 1ns/1ps
`default_nettype none
module external_memory_controller_sva (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       req_done,
    input wire logic [7:0] bank_select_n,
    input wire logic [7:0] lane_write_en_n,
    input wire logic       mem_output_en_n,
    input wire logic       sdram_row_strobe_n,
    input wire logic       sdram_col_strobe_n,
    input wire logic [7:0] prog_byte_select_n,
    input wire logic [5:0] prog_line,
    input wire logic       prog_machine_wait,
    input wire logic       addr_latch_en,
    input wire logic       sdram_addr_mux_ctrl,
    input wire logic       ext_master_mode,
    input wire logic       parity_chip_select_n,
    input wire logic       parity_sep_en,
    input wire logic [1:0] buffer_ctrl_config,
    input wire logic       buffer_ctrl_a,
    input wire logic       buffer_ctrl_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Three stalled samples let the registered outputs settle on the held step.
    sequence s_stall;
        prog_machine_wait [*3];
    endsequence
    sequence s_off;
        buffer_ctrl_config == 2'h3 [*2];
    endsequence

    a_bank_onehot: assert property ($onehot0(~bank_select_n))
        else $error("more than one bank select active");
    a_read_no_write: assert property (!mem_output_en_n |-> &lane_write_en_n)
        else $error("write lane active during read");
    a_lane_needs_bank: assert property (!(&lane_write_en_n) |-> !(&bank_select_n))
        else $error("write lane without bank select");
    a_one_machine: assert property ((!(&lane_write_en_n) || !mem_output_en_n)
        |-> sdram_row_strobe_n && sdram_col_strobe_n && &prog_byte_select_n)
        else $error("two machines drive strobes");
    a_sdram_bank: assert property ((!sdram_row_strobe_n || !sdram_col_strobe_n)
        |-> !(&bank_select_n))
        else $error("sdram strobe without bank select");
    a_latch_ext_only: assert property (addr_latch_en |-> ext_master_mode)
        else $error("address latch outside external mode");
    a_mux_ext_only: assert property (sdram_addr_mux_ctrl |-> ext_master_mode)
        else $error("address mux outside external mode");
    a_parity_gate: assert property (!parity_chip_select_n |-> parity_sep_en)
        else $error("parity select while parity not separate");
    a_buffer_off: assert property (s_off |-> !buffer_ctrl_a && !buffer_ctrl_b)
        else $error("buffer control active while off");
    a_stall_hold: assert property (s_stall |-> $stable(prog_line) && $stable(prog_byte_select_n))
        else $error("user machine advanced during wait");
    a_done_pulse: assert property (req_done |=> !req_done)
        else $error("done longer than one cycle");
endmodule
`default_nettype wire
bind external_memory_controller external_memory_controller_sva u_sva (.clk_sys, .rst,
    .req_done, .bank_select_n, .lane_write_en_n, .mem_output_en_n, .sdram_row_strobe_n,
    .sdram_col_strobe_n, .prog_byte_select_n, .prog_line, .prog_machine_wait, .addr_latch_en,
    .sdram_addr_mux_ctrl, .ext_master_mode, .parity_chip_select_n, .parity_sep_en,
    .buffer_ctrl_config, .buffer_ctrl_a, .buffer_ctrl_b);

//--- sim/external_memory_controller_test.sv
// Self-checking bench for the external memory controller pin block.
`timescale 1ns/1ps
`default_nettype none
module external_memory_controller_test;
    logic        clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, req_burst = 0;
    logic        ext_master_mode = 0, parity_sep_en = 0;
    logic [31:0] req_addr = 32'h0, bank_port_size = 32'h0;
    logic [2:0]  req_bank = 3'h0;
    logic [3:0]  req_size = 4'h1, prog_bs_pattern = 4'hf, ack_dly = 4'h2, wait_len = 4'h0;
    logic [15:0] bank_machine = 16'h00e4;
    logic [23:0] prog_pattern = 24'h204081;
    logic [1:0]  buffer_ctrl_config = 2'h0;
    wire logic   chipsel_machine_ack, prog_machine_wait, req_ready, req_done, mem_output_en_n;
    wire logic   sdram_addr_bit_ten, sdram_write_strobe_n, sdram_row_strobe_n;
    wire logic   sdram_col_strobe_n, sdram_addr_mux_ctrl, addr_latch_en, parity_chip_select_n;
    wire logic   buffer_ctrl_a, buffer_ctrl_b;
    wire logic [7:0] bank_select_n, lane_write_en_n, sdram_byte_mask, prog_byte_select_n;
    wire logic [5:0] prog_line;
    wire logic [1:0] burst_addr_bits;
    int          n_mismatch = 0, comparisons = 0, cyc, nack, d;
    logic [7:0]  bs, wn, mk, pb;
    logic [5:0]  gl;
    logic [3:0]  bb;
    logic        oe, rs, cs, al, mx, pr, bf, dn, we, ar, ac;

    external_memory_controller uut (.*);
    mem_device_model dev (.*);

    // Free-running system clock at 250 MHz.
    always #2 clk_sys = ~clk_sys;

    task print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // One access; pin activity is gathered as a union so that timing freedom is kept.
    task run(input logic [2:0] b, input logic w, input logic [31:0] a, input logic [3:0] sz,
             input logic bu);
        int i;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (req_ready !== 1'b1) begin
            n_mismatch++;
            print_verdict;
        end
        {req_valid, req_bank, req_write, req_addr, req_size, req_burst} = {1'b1, b, w, a, sz, bu};
        {bs, wn, mk, pb, gl, bb} = {8'hff, 8'h0, 8'h0, 8'h0, 6'h0, 4'h0};
        {oe, rs, cs, al, mx, pr, bf, dn, we, ar, ac, cyc, nack} = 0;
        @(posedge clk_sys);
        #1;
        req_valid = 0;
        // Sampling starts just after the taking edge, so the one-cycle latch pulse is seen.
        for (i = 0; i < 200 && !dn; i++) begin
            bs &= bank_select_n;
            wn |= ~lane_write_en_n;
            mk |= ~sdram_byte_mask;
            pb |= ~prog_byte_select_n;
            gl |= prog_line;
            if (bank_select_n != 8'hff) bb[burst_addr_bits] = 1'b1;
            {oe, rs, cs} |= {!mem_output_en_n, !sdram_row_strobe_n, !sdram_col_strobe_n};
            {al, mx, pr} |= {addr_latch_en, sdram_addr_mux_ctrl, !parity_chip_select_n};
            bf |= buffer_ctrl_a | buffer_ctrl_b;
            we |= !sdram_write_strobe_n;
            if (!sdram_row_strobe_n) ar = sdram_addr_bit_ten;
            if (!sdram_col_strobe_n) ac = sdram_addr_bit_ten;
            nack += chipsel_machine_ack;
            dn = req_done;
            if (!dn) begin
                @(posedge clk_sys);
                #1;
                cyc++;
            end
        end
        if (dn !== 1'b1) begin
            n_mismatch++;
            print_verdict;
        end
    endtask

    task t_cs;
        run(3'h0, 1'b1, 32'h2, 4'h2, 1'b0);
        chk("bank", bs, 8'hfe);
        chk("lanes", $countones(wn), 2);
        chk("oe", oe, 0);
        chk("acks", nack, 1);
        chk("ras", rs, 0);
        chk("buf", bf, 1);
        run(3'h4, 1'b0, 32'h0, 4'h8, 1'b0);
        chk("bank4", bs, 8'hef);
        chk("oe_rd", oe, 1);
        chk("wr_rd", wn, 0);
        ack_dly = 4'h4;
        run(3'h0, 1'b0, 32'h10, 4'h8, 1'b1);
        chk("burst", bb, 4'hf);
        chk("acks4", nack, 4);
    endtask

    task t_up;
        run(3'h1, 1'b1, 32'h0, 4'h4, 1'b0);
        d = cyc;
        chk("lines", gl, 6'h0f);
        chk("bsel", $countones(pb), 4);
        chk("wr_up", wn, 0);
        wait_len = 4'h6;
        run(3'h1, 1'b1, 32'h0, 4'h4, 1'b0);
        chk("stall", cyc >= d + 5, 1);
        wait_len = 4'h0;
        bank_port_size = 32'h40;
        run(3'h1, 1'b0, 32'h6, 4'h2, 1'b0);
        chk("bsel_port", pb, 8'h0c);
        bank_port_size = 32'h0;
    endtask

    task t_sd;
        {ext_master_mode, parity_sep_en} = 2'b11;
        run(3'h2, 1'b1, 32'h8, 4'h1, 1'b0);
        chk("rascas", {rs, cs}, 2'b11);
        chk("mask", $countones(mk), 1);
        chk("ale", al, 1);
        chk("mux", mx, 1);
        chk("par", pr, 1);
        chk("wr_sd", wn, 0);
        chk("we_sd", we, 1);
        chk("a10_row", ar, 0);
        chk("a10_col", ac, 1);
        {ext_master_mode, parity_sep_en} = 2'b00;
        run(3'h2, 1'b0, 32'h408, 4'h1, 1'b0);
        chk("ale0", {al, mx, pr}, 3'b000);
        chk("a10_row1", ar, 1);
        chk("we_rd", we, 0);
    endtask

    task t_none;
        buffer_ctrl_config = 2'h3;
        {req_bank, req_valid} = {3'h3, 1'b1};
        dn = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            dn |= req_done | (bank_select_n != 8'hff);
        end
        req_valid = 0;
        chk("none", dn, 0);
        run(3'h0, 1'b0, 32'h0, 4'h8, 1'b0);
        chk("buf_off", bf, 0);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        chk("ready_rst", req_ready, 0);
        chk("bank_rst", bank_select_n, 8'hff);
        rst = 0;
        @(posedge clk_sys);
        #1;
        chk("ready", req_ready, 1);
        t_cs;
        t_up;
        t_sd;
        t_none;
        print_verdict;
    end
endmodule
`default_nettype wire
